//--- design/hpt_pkg.sv
// host port package: constants, state and carrier types
// assumes one 250 MHz clock mclk and active-low asynchronous reset rst_n
// Behaviour
// R1: select lines pick one of three registers
// R2: byte ident places first or second byte
// R3: host holds chip select low per access
// R4: host strobes drive the two data strobes
// R5: address strobe latches address in multiplexed mode
// R6: read_write_sel high reads, low writes
// R7: ready output shows port can take transfer
// R8: ready floats while outputs-disable is low
// R9: host irq high while device in reset
// R10: host irq floats while outputs-disable is low
// R11: enable strap sampled at reset release
// R12: strap low or open disables port
// R13: disabled port ignores strap until reset
// R14: width strap high selects non-multiplexed mode
// R15: wide mode uses 16 address, 16 data pins
// R16: wide mode has no host interrupts
// R17: wide mode hides control and address registers
// R18: width strap captured at reset, held
// R19: system keeps width strap stable out of reset
// R20: width strap low gives byte-wide mode
// R21: byte mode uses 8-bit bidirectional data bus
// R22: host waits for ready before next strobe
`default_nettype none

package hpt_pkg;

  // ==========================================================
  // register selects and field positions
  localparam logic [1:0] HPT_SEL_CTRL = 2'h0;
  localparam logic [1:0] HPT_SEL_DATA_INC = 2'h1;
  localparam logic [1:0] HPT_SEL_ADDR = 2'h2;
  localparam logic [1:0] HPT_SEL_DATA = 2'h3;
  localparam int HPT_CTRL_IRQ_BIT = 3;
  localparam logic [15:0] HPT_CTRL_RESET = 16'h0000;
  localparam logic [15:0] HPT_ADDR_RESET = 16'h0000;

  // ==========================================================
  // timing: internal memory access latency
  localparam int HPT_ACCESS_NS = 8;
  localparam int HPT_CLK_NS = 4;
  localparam int HPT_ACCESS_CYC = (HPT_ACCESS_NS + HPT_CLK_NS - 1) / HPT_CLK_NS;
  localparam logic [2:0] HPT_ACCESS_CNT = 3'(HPT_ACCESS_CYC);

  typedef enum logic [2:0] {
    HPT_IDLE   = 3'b001,
    HPT_BUSY   = 3'b010,
    HPT_FINISH = 3'b100
  } hpt_state_t;

  // host control pins after synchronising
  typedef struct packed {
    logic       cs_n;
    logic       ds_a_n;
    logic       ds_b_n;
    logic       as_n;
    logic       rw;
    logic       bident;
    logic [1:0] sel;
  } hpt_ctl_t;

  // internal memory request
  typedef struct packed {
    logic        req;
    logic        wr;
    logic [15:0] addr;
    logic [15:0] wdata;
  } hpt_mem_req_t;

endpackage : hpt_pkg

`default_nettype wire

//--- design/hpt_host_port.sv
// host port: control pins, address latch, byte pairing, ready and host irq
// assumes a single-cycle-acknowledge memory beyond mem_req after HPT_ACCESS_CYC
`default_nettype none

module hpt_host_port
  import hpt_pkg::*;
(
  // clock and reset
  input  wire logic         mclk,
  input  wire logic         rst_n,
  // straps
  input  wire logic         port_enable_strap,
  input  wire logic         width_select_strap,
  input  wire logic         outputs_disable_n,
  // host control pins
  input  wire logic         reg_select_0,
  input  wire logic         reg_select_1,
  input  wire logic         byte_ident,
  input  wire logic         port_chip_select_n,
  input  wire logic         data_strobe_a_n,
  input  wire logic         data_strobe_b_n,
  input  wire logic         addr_strobe_n,
  input  wire logic         read_write_sel,
  // host data and address pins
  input  wire logic [15:0]  host_addr_in,
  input  wire logic [15:0]  host_data_in,
  output logic      [15:0]  host_data_out,
  output logic      [15:0]  host_data_oe,
  // ready and interrupt pins
  output logic              port_ready,
  output logic              port_ready_oe,
  output logic              host_irq,
  output logic              host_irq_oe,
  // device side
  input  wire logic         dev_irq_set,
  input  wire logic [15:0]  mem_rdata,
  output hpt_mem_req_t      mem_req,
  output logic              port_enabled,
  output logic              byte_wide_mode
);

  // ==========================================================
  // pin synchronisers
  hpt_ctl_t   ctl_meta_reg, ctl_reg, ctl_prev_reg;
  logic [1:0] ods_sync_reg;
  logic       strobe_n, strobe_prev_n, strobe_fall, as_fall;
  logic [15:0] addr_meta_reg, addr_sync_reg, data_meta_reg, data_sync_reg;

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      ctl_meta_reg  <= '1;
      ctl_reg       <= '1;
      ctl_prev_reg  <= '1;
      ods_sync_reg  <= 2'h3;
      addr_meta_reg <= 16'h0000;
      addr_sync_reg <= 16'h0000;
      data_meta_reg <= 16'h0000;
      data_sync_reg <= 16'h0000;
    end else begin
      ctl_meta_reg  <= '{port_chip_select_n, data_strobe_a_n, data_strobe_b_n, addr_strobe_n,
                         read_write_sel, byte_ident, {reg_select_1, reg_select_0}};
      ctl_reg       <= ctl_meta_reg;
      ctl_prev_reg  <= ctl_reg;
      ods_sync_reg  <= {ods_sync_reg[0], outputs_disable_n};
      addr_meta_reg <= host_addr_in;
      addr_sync_reg <= addr_meta_reg;
      data_meta_reg <= host_data_in;
      data_sync_reg <= data_meta_reg;
    end
  end

  // strobe is active when chip select and either data strobe are low
  assign strobe_n      = ctl_reg.cs_n | (ctl_reg.ds_a_n & ctl_reg.ds_b_n);           // R3 R4
  assign strobe_prev_n = ctl_prev_reg.cs_n | (ctl_prev_reg.ds_a_n & ctl_prev_reg.ds_b_n);
  assign strobe_fall   = strobe_prev_n & ~strobe_n;
  assign as_fall       = ctl_prev_reg.as_n & ~ctl_reg.as_n & ~ctl_reg.cs_n;

  // ==========================================================
  // straps: caught on the first clock after reset release
  logic       strap_done_reg, enable_reg, wide_reg;
  logic [1:0] en_strap_sync_reg, wide_strap_sync_reg;

  // no reset here: the synchroniser keeps running through reset so it has settled at release
  always_ff @(posedge mclk) begin
    en_strap_sync_reg   <= {en_strap_sync_reg[0], port_enable_strap};
    wide_strap_sync_reg <= {wide_strap_sync_reg[0], width_select_strap};
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      strap_done_reg <= 1'b0;
      enable_reg     <= 1'b0;
      wide_reg       <= 1'b0;
    end else if (!strap_done_reg) begin
      strap_done_reg <= 1'b1;
      enable_reg     <= en_strap_sync_reg[1];                                         // R11 R12
      wide_reg       <= wide_strap_sync_reg[1];                                       // R14 R18 R20
    end
  end
  // once strap_done is set, later strap changes are never looked at        R13

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      port_enabled   <= 1'b0;
      byte_wide_mode <= 1'b0;
    end else begin
      port_enabled   <= enable_reg & strap_done_reg;
      byte_wide_mode <= strap_done_reg & ~wide_reg;
    end
  end

  // ==========================================================
  // port registers and transfer machine
  hpt_state_t  state_reg;
  logic [15:0] ctrl_reg, addr_reg, wlatch_reg, rdata_reg;
  logic [2:0]  wait_reg;
  logic        active, go_byte, go_wide, is_ctrl, is_addr, last_byte;

  assign active    = port_enabled & (state_reg == HPT_IDLE) & strobe_fall;
  assign go_wide   = active & ~byte_wide_mode;
  assign go_byte   = active & byte_wide_mode;
  assign is_ctrl   = ctl_reg.sel == HPT_SEL_CTRL;                                     // R1
  assign is_addr   = ctl_reg.sel == HPT_SEL_ADDR;                                     // R1
  assign last_byte = ctl_reg.bident;                                                  // R2

  function automatic logic [15:0] put_byte(input logic [15:0] w, input logic hi_n, input logic [7:0] b);
    put_byte = hi_n ? {w[15:8], b} : {b, w[7:0]};
  endfunction : put_byte

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      addr_reg <= HPT_ADDR_RESET;
    end else if (byte_wide_mode & as_fall) begin
      addr_reg <= put_byte(addr_reg, last_byte, data_sync_reg[7:0]);                  // R5
    end else if (go_byte & is_addr & ~ctl_reg.rw) begin
      addr_reg <= put_byte(addr_reg, last_byte, data_sync_reg[7:0]);                  // R1 R2
    end else if (go_wide) begin
      addr_reg <= addr_sync_reg;                                                      // R15 R17
    end else if (go_byte & (ctl_reg.sel == HPT_SEL_DATA_INC) & last_byte) begin
      addr_reg <= addr_reg + 16'h0001;
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      wlatch_reg <= 16'h0000;
    end else if (go_byte & ~ctl_reg.rw) begin
      wlatch_reg <= put_byte(wlatch_reg, last_byte, data_sync_reg[7:0]);             // R2 R6
    end
  end

  // host irq bit: device sets, host clears by writing one; set wins
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      ctrl_reg <= HPT_CTRL_RESET;
    end else if (!byte_wide_mode) begin
      ctrl_reg <= HPT_CTRL_RESET;                                                     // R16
    end else if (dev_irq_set) begin
      ctrl_reg[HPT_CTRL_IRQ_BIT] <= 1'b1;
    end else if (go_byte & is_ctrl & ~ctl_reg.rw & last_byte &
                 data_sync_reg[HPT_CTRL_IRQ_BIT]) begin
      ctrl_reg[HPT_CTRL_IRQ_BIT] <= 1'b0;
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      state_reg <= HPT_IDLE;
      wait_reg  <= 3'h0;
      mem_req   <= '0;
      rdata_reg <= 16'h0000;
    end else begin
      mem_req.req <= 1'b0;
      case (state_reg)
        HPT_IDLE: begin
          if (go_wide | (go_byte & ~is_ctrl & ~is_addr & last_byte)) begin
            state_reg     <= HPT_BUSY;
            wait_reg      <= HPT_ACCESS_CNT;
            mem_req.req   <= 1'b1;
            mem_req.wr    <= ~ctl_reg.rw;                                             // R6
            mem_req.addr  <= go_wide ? addr_sync_reg : addr_reg;                      // R15
            mem_req.wdata <= go_wide ? data_sync_reg
                                     : put_byte(wlatch_reg, 1'b1, data_sync_reg[7:0]);
          end else if (active) begin
            state_reg <= HPT_FINISH;
          end
        end
        HPT_BUSY: begin
          wait_reg <= wait_reg - 3'h1;
          if (wait_reg == 3'h1) begin
            rdata_reg <= mem_rdata;
            state_reg <= HPT_FINISH;
          end
        end
        HPT_FINISH: begin
          if (strobe_n) begin
            state_reg <= HPT_IDLE;
          end
        end
        default: state_reg <= HPT_IDLE;
      endcase
    end
  end

  // ==========================================================
  // pin outputs, all from flip-flops
  logic [15:0] rd_word;
  assign rd_word = is_ctrl ? ctrl_reg : (is_addr ? addr_reg : rdata_reg);

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      port_ready    <= 1'b0;
      port_ready_oe <= 1'b0;
      host_irq      <= 1'b1;                                                          // R9
      host_irq_oe   <= 1'b1;                                                          // R9
      host_data_out <= 16'h0000;
      host_data_oe  <= 16'h0000;
    end else begin
      // ready drops as soon as a strobe is taken: busy is slower than the host
      port_ready    <= port_enabled & (state_reg == HPT_IDLE) & ~strobe_fall;         // R7 R22
      port_ready_oe <= port_enabled & ods_sync_reg[1];                                // R8
      host_irq      <= ~(byte_wide_mode & ctrl_reg[HPT_CTRL_IRQ_BIT]);                // R16
      host_irq_oe   <= port_enabled & byte_wide_mode & ods_sync_reg[1];               // R10
      if (byte_wide_mode) begin
        // byte frozen at the take so a read's own prefetch cannot change it mid-strobe
        if (active) begin
          host_data_out <= {8'h00, last_byte ? rd_word[7:0] : rd_word[15:8]};         // R21 R2
        end
        host_data_oe  <= {8'h00, {8{port_enabled & ~strobe_n & ctl_reg.rw & ods_sync_reg[1]}}};
      end else begin
        host_data_out <= rdata_reg;                                                   // R15
        host_data_oe  <= {16{port_enabled & ~strobe_n & ctl_reg.rw & ods_sync_reg[1]}};
      end
    end
  end

  // ==========================================================
  // checks
  chk_irq_reset_high: assert property (@(posedge mclk) !rst_n |-> host_irq && host_irq_oe)   // R9
    else $error("host irq not high in reset");
  chk_ready_float: assert property (@(posedge mclk) disable iff (!rst_n)
      !ods_sync_reg[1] |=> !port_ready_oe)   // R8
    else $error("ready driven while outputs disabled");
  chk_irq_float: assert property (@(posedge mclk) disable iff (!rst_n)
      !ods_sync_reg[1] |=> !host_irq_oe)   // R10
    else $error("irq driven while outputs disabled");
  chk_strap_hold: assert property (@(posedge mclk) disable iff (!rst_n)
      $past(strap_done_reg) |-> $stable(enable_reg) && $stable(wide_reg))   // R13
    else $error("strap value changed after capture");
  chk_disabled_idle: assert property (@(posedge mclk) disable iff (!rst_n)
      !port_enabled |-> !mem_req.req && !port_ready)   // R12
    else $error("disabled port active");
  chk_wide_no_irq: assert property (@(posedge mclk) disable iff (!rst_n)
      strap_done_reg && wide_reg |=> ##1 host_irq && !host_irq_oe)   // R16
    else $error("irq in wide mode");
  chk_ready_drop: assert property (@(posedge mclk) disable iff (!rst_n)
      active |=> !port_ready ##1 !port_ready)   // R7
    else $error("ready kept high after strobe");
  chk_access_len: assert property (@(posedge mclk) disable iff (!rst_n)
      mem_req.req |-> ##[1:3] state_reg == HPT_FINISH)   // R15
    else $error("memory access too long");
  chk_rw_dir: assert property (@(posedge mclk) disable iff (!rst_n)
      mem_req.req |-> mem_req.wr == !$past(ctl_reg.rw))   // R6
    else $error("direction wrong");
  cov_byte_access: cover property (@(posedge mclk) go_byte && last_byte);
  cov_wide_access: cover property (@(posedge mclk) go_wide);
  cov_addr_strobe: cover property (@(posedge mclk) byte_wide_mode && as_fall);
  cov_irq_raise: cover property (@(posedge mclk) $fell(host_irq));

endmodule : hpt_host_port

`default_nettype wire

//--- testbench/hpt_host_model.sv
// host processor model: drives the port's control, address and data pins
// assumes the bench calls its tasks; pins change on falling mclk only
`default_nettype none

module hpt_host_model
  import hpt_pkg::*;
(
  // clock and answers
  input  wire logic        mclk,
  input  wire logic        port_ready,
  input  wire logic [15:0] host_data_out,
  input  wire logic [15:0] host_data_oe,
  // driven pins
  output logic      [1:0]  sel,
  output logic             byte_ident,
  output logic             port_chip_select_n,
  output logic             data_strobe_a_n,
  output logic             data_strobe_b_n,
  output logic             addr_strobe_n,
  output logic             read_write_sel,
  output logic      [15:0] host_addr_in,
  output logic      [15:0] host_data_in
);
  timeunit 1ns;
  timeprecision 1ps;
  logic use_b = 1'b0;

  initial begin
    {sel, byte_ident, read_write_sel} = 4'hF;
    {port_chip_select_n, data_strobe_a_n, data_strobe_b_n, addr_strobe_n} = 4'hF;
    host_addr_in = 16'h0000;
    host_data_in = 16'h0000;
  end

  task automatic wait_rdy(input logic lvl, output logic ok);
    int n;
    n = 0;
    while (port_ready !== lvl && n < 40) begin
      @(negedge mclk);
      n++;
    end
    ok = (port_ready === lvl);
  endtask : wait_rdy

  // ==========================================================
  // one strobed transfer; take=0 for a port that must ignore it
  task automatic xfer(input logic [1:0] s, input logic bid, input logic rd, input logic [15:0] a,
                      input logic [15:0] wd, input logic take, output logic [15:0] seen, output logic ok);
    logic ok0;
    ok0 = 1'b1;
    if (take) wait_rdy(1'b1, ok0);
    ok = ok0;
    @(negedge mclk);
    sel = s;
    byte_ident = bid;
    read_write_sel = rd;
    host_addr_in = a;
    host_data_in = wd;
    port_chip_select_n = 1'b0;
    @(negedge mclk);
    if (use_b) data_strobe_b_n = 1'b0;
    else data_strobe_a_n = 1'b0;
    if (take) wait_rdy(1'b0, ok0);
    ok = ok && ok0;
    repeat (4) @(negedge mclk);
    seen = {host_data_oe[7:0], host_data_out[7:0]};
    data_strobe_a_n = 1'b1;
    data_strobe_b_n = 1'b1;
    port_chip_select_n = 1'b1;
    // released bus shows the inverse so a stale value cannot pass
    host_data_in = ~host_data_in;
    use_b = ~use_b;
    if (take) wait_rdy(1'b1, ok0);
    ok = ok && ok0;
  endtask : xfer

  task automatic latch_addr(input logic bid, input logic [7:0] b);
    @(negedge mclk);
    byte_ident = bid;
    host_data_in = {8'h00, b};
    port_chip_select_n = 1'b0;
    @(negedge mclk);
    addr_strobe_n = 1'b0;
    repeat (4) @(negedge mclk);
    addr_strobe_n = 1'b1;
    port_chip_select_n = 1'b1;
    host_data_in = ~host_data_in;
    repeat (3) @(negedge mclk);
  endtask : latch_addr
endmodule : hpt_host_model

`default_nettype wire

//--- testbench/tb_top.sv
// self-checking bench for the host port: byte mode, wide mode, disabled port
// assumes hpt_pkg and the host model are compiled first
`default_nettype none

module tb_top
  import hpt_pkg::*;
();
  timeunit 1ns;
  timeprecision 1ps;
  // reset starts released so the first do_reset makes a real falling edge
  logic mclk = 1'b0, rst_n = 1'b1, en_s = 1'b0, wide_s = 1'b0, odis_n = 1'b1, irq_set = 1'b0;
  logic [15:0] mem_rdata = 16'h0000, hdo, hdoe, haddr, hdata;
  logic [1:0] sel;
  logic bid, cs_n, dsa_n, dsb_n, as_n, rw, rdy, rdy_oe, irq, irq_oe, p_en, b_mode;
  hpt_mem_req_t mem_req, last_req = '0;
  int req_cnt = 0, err_total = 0, n_compared = 0;
  logic [31:0] rng = 32'h0000003E;

  initial forever #2 mclk = ~mclk;

  hpt_host_port dut_u (.mclk(mclk), .rst_n(rst_n), .port_enable_strap(en_s), .width_select_strap(wide_s),
    .outputs_disable_n(odis_n), .reg_select_0(sel[0]), .reg_select_1(sel[1]), .byte_ident(bid),
    .port_chip_select_n(cs_n), .data_strobe_a_n(dsa_n), .data_strobe_b_n(dsb_n), .addr_strobe_n(as_n),
    .read_write_sel(rw), .host_addr_in(haddr), .host_data_in(hdata), .host_data_out(hdo),
    .host_data_oe(hdoe), .port_ready(rdy), .port_ready_oe(rdy_oe), .host_irq(irq), .host_irq_oe(irq_oe),
    .dev_irq_set(irq_set), .mem_rdata(mem_rdata), .mem_req(mem_req), .port_enabled(p_en),
    .byte_wide_mode(b_mode));

  hpt_host_model host_u (.mclk(mclk), .port_ready(rdy), .host_data_out(hdo), .host_data_oe(hdoe),
    .sel(sel), .byte_ident(bid), .port_chip_select_n(cs_n), .data_strobe_a_n(dsa_n),
    .data_strobe_b_n(dsb_n), .addr_strobe_n(as_n), .read_write_sel(rw), .host_addr_in(haddr),
    .host_data_in(hdata));

  // ==========================================================
  // memory beyond the port: records each request, answers a known word
  always @(posedge mclk) if (mem_req.req === 1'b1) begin
    last_req <= mem_req;
    req_cnt <= req_cnt + 1;
  end
  always @(negedge mclk) mem_rdata <= ~last_req.addr;

  function automatic logic [31:0] xs(input logic [31:0] v);
    v = v ^ (v << 13);
    v = v ^ (v >> 17);
    return v ^ (v << 5);
  endfunction : xs

  function automatic logic [15:0] next_addr(input logic [15:0] a);
    return a + 16'h0001;
  endfunction : next_addr

  task automatic rnd(output logic [15:0] r);
    rng = xs(rng);
    r = rng[15:0];
  endtask : rnd

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    n_compared++;
    if (seen !== exp) begin
      err_total++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check

  task automatic end_of_test();
    $display("compared %0d mismatched %0d", n_compared, err_total);
    if (err_total == 0 && n_compared > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask : end_of_test

  task automatic must(input logic ok);
    check({15'h0000, ok}, 16'h0001);
    if (ok !== 1'b1) begin
      end_of_test();
    end
  endtask : must

  task automatic wr_word(input logic [1:0] s, input logic [15:0] w);
    logic [15:0] d;
    logic ok;
    host_u.xfer(s, 1'b0, 1'b0, 16'h0000, {8'h00, w[15:8]}, 1'b1, d, ok);
    must(ok);
    host_u.xfer(s, 1'b1, 1'b0, 16'h0000, {8'h00, w[7:0]}, 1'b1, d, ok);
    must(ok);
  endtask : wr_word

  task automatic do_reset(input logic en, input logic wide);
    @(negedge mclk);
    rst_n = 1'b0;
    en_s = en;
    wide_s = wide;
    repeat (6) @(negedge mclk);
    check({15'h0000, irq}, 16'h0001);
    check({13'h0000, irq_oe, rdy_oe, mem_req.req}, 16'h0004);
    rst_n = 1'b1;
    repeat (4) @(negedge mclk);
    check({15'h0000, p_en}, {15'h0000, en});
  endtask : do_reset

  task automatic pulse_irq();
    irq_set = 1'b1;
    @(negedge mclk);
    irq_set = 1'b0;
    repeat (3) @(negedge mclk);
  endtask : pulse_irq

  initial begin
    logic [15:0] a, w, d, e;
    logic ok;
    int c0;
    do_reset(1'b1, 1'b0);
    check({15'h0000, b_mode}, 16'h0001);
    check({15'h0000, rdy}, 16'h0001);
    for (int i = 0; i < 6; i++) begin
      rnd(a);
      rnd(w);
      if (i[0]) begin
        host_u.latch_addr(1'b0, a[15:8]);
        host_u.latch_addr(1'b1, a[7:0]);
      end else begin
        wr_word(HPT_SEL_ADDR, a);
      end
      c0 = req_cnt;
      wr_word(HPT_SEL_DATA, w);
      check(16'(req_cnt - c0), 16'h0001);
      check(last_req.addr, a);
      check(last_req.wdata, w);
      check({15'h0000, last_req.wr}, 16'h0001);
      wr_word(HPT_SEL_DATA_INC, ~w);
      wr_word(HPT_SEL_DATA_INC, w);
      check(last_req.addr, next_addr(a));
      e = ~next_addr(a);
      for (int b = 0; b < 2; b++) begin
        host_u.xfer(HPT_SEL_DATA, b[0], 1'b1, a, w, 1'b1, d, ok);
        must(ok);
        check({8'h00, d[15:8]}, 16'h00FF);
        check({8'h00, d[7:0]}, {8'h00, b[0] ? e[7:0] : e[15:8]});
      end
      check({15'h0000, last_req.wr}, 16'h0000);
    end
    pulse_irq();
    check({15'h0000, irq}, 16'h0000);
    wr_word(HPT_SEL_CTRL, 16'h0001 << HPT_CTRL_IRQ_BIT);
    check({15'h0000, irq}, 16'h0001);
    odis_n = 1'b0;
    repeat (4) @(negedge mclk);
    check({14'h0000, rdy_oe, irq_oe}, 16'h0000);
    check(hdoe, 16'h0000);
    host_u.xfer(HPT_SEL_CTRL, 1'b1, 1'b1, a, w, 1'b1, d, ok);
    must(ok);
    check({8'h00, d[15:8]}, 16'h0000);
    check({15'h0000, rdy_oe}, 16'h0000);
    odis_n = 1'b1;
    repeat (4) @(negedge mclk);
    check({15'h0000, rdy_oe}, 16'h0001);
    do_reset(1'b1, 1'b1);
    check({15'h0000, b_mode}, 16'h0000);
    for (int i = 0; i < 4; i++) begin
      rnd(a);
      rnd(w);
      host_u.xfer(2'(i), w[0], 1'b0, a, w, 1'b1, d, ok);
      must(ok);
      check(last_req.addr, a);
      check(last_req.wdata, w);
    end
    host_u.xfer(HPT_SEL_DATA, 1'b0, 1'b1, a, w, 1'b1, d, ok);
    must(ok);
    e = ~a;
    check(d, {8'hFF, e[7:0]});
    check(hdo, e);
    check({15'h0000, last_req.wr}, 16'h0000);
    pulse_irq();
    check({14'h0000, irq_oe, irq}, 16'h0001);
    do_reset(1'b0, 1'b0);
    en_s = 1'b1;
    repeat (4) @(negedge mclk);
    check({15'h0000, p_en}, 16'h0000);
    c0 = req_cnt;
    host_u.xfer(HPT_SEL_DATA, 1'b1, 1'b0, a, w, 1'b0, d, ok);
    check(16'(req_cnt - c0), 16'h0000);
    end_of_test();
  end
endmodule : tb_top

`default_nettype wire
